// ===== include/timer16_pkg.sv
// shared register map, field layout and reset values of the 16-bit timer
package timer16_pkg;
  // register byte addresses on the axi4-lite slave
  localparam logic [7:0] ctrl_offset = 8'h00;
  localparam logic [7:0] count_low_offset = 8'h04;
  localparam logic [7:0] count_high_offset = 8'h08;
  localparam logic [7:0] status_offset = 8'h0c;
  localparam logic [7:0] crystal_pins_offset = 8'h10;
  // control register field positions
  localparam int timer_on_bit = 0;
  localparam int clock_source_select_bit = 1;
  localparam int external_sync_disable_bit = 2;
  localparam int low_power_osc_enable_bit = 3;
  localparam int prescale_select_lsb = 4;
  // status register field positions
  localparam int rollover_flag_bit = 0;
  localparam int armed_bit = 1;
  localparam int osc_usable_bit = 2;
  // crystal pin readback field positions
  localparam int pin_a_dir_bit = 0;
  localparam int pin_b_dir_bit = 1;
  localparam int pin_a_data_bit = 2;
  localparam int pin_b_data_bit = 3;
  // reset values and the counter top value
  localparam logic [7:0] ctrl_reset = 8'h00;
  localparam logic [15:0] count_reset = 16'h0000;
  localparam logic [15:0] count_max = 16'hffff;
  // instruction clock is the core clock divided by four
  localparam logic [1:0] instr_phase_last = 2'h3;
  // axi response codes
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
endpackage : timer16_pkg

// ===== rtl/clock_edge_detect.sv
// edge detector for the external count clock, synchronised or direct
module clock_edge_detect (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic level,
  input wire logic sync_bypass,
  output logic rise,
  output logic fall
);
  typedef struct packed {
    logic direct;  // single sample for direct counting
    logic sync_a;  // synchroniser first stage
    logic sync_b;  // synchroniser second stage
    logic prev;    // last selected level
  } edge_state_t;

  edge_state_t s;
  edge_state_t next_s;
  logic cur;

  // the first stage feeds only the second; direct path has its own flop
  always_comb begin
    next_s = s;
    next_s.direct = level;
    next_s.sync_a = level;
    next_s.sync_b = s.sync_a;
    cur = sync_bypass ? s.direct : s.sync_b;
    next_s.prev = cur;
    rise = cur & ~s.prev;
    fall = ~cur & s.prev;
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule : clock_edge_detect

// ===== rtl/count_prescaler.sv
// 1/2/4/8 prescaler with a synchronous clear, invisible to software
module count_prescaler (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic clear,
  input wire logic [1:0] prescale_select,
  output logic pulse
);
  typedef struct packed {
    logic [2:0] cnt;  // hidden prescale count
    logic pulse;      // one tick out per n ticks in
  } pre_state_t;

  pre_state_t s;
  pre_state_t next_s;
  logic [2:0] limit;

  // 00 -> 1:1, 01 -> 1:2, 10 -> 1:4, 11 -> 1:8
  always_comb begin
    next_s = s;
    limit = 3'((4'h1 << prescale_select) - 4'h1);
    next_s.pulse = 1'b0;
    if (clear) begin
      next_s.cnt = 3'h0;
    end else if (tick) begin
      if (s.cnt == limit) begin
        next_s.cnt = 3'h0;
        next_s.pulse = 1'b1;
      end else begin
        next_s.cnt = s.cnt + 3'h1;
      end
    end
    pulse = s.pulse;
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule : count_prescaler

// ===== rtl/gated_timer16.sv
// 16-bit timer/counter with prescaler, crystal option and axi4-lite registers
//
// Added by the designer: register access over AXI4-Lite and the register addresses.
module gated_timer16
  import timer16_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // clock inputs and system state
  input wire logic external_clock_pin,
  input wire logic low_power_crystal_osc,
  input wire logic osc_mode_lp_or_intosc,
  input wire logic sleep_mode,
  // port pin state from the general-purpose port
  input wire logic port_pin_a_direction,
  input wire logic port_pin_b_direction,
  input wire logic port_pin_a_data,
  input wire logic port_pin_b_data,
  // outputs
  output logic crystal_pin_a_direction,
  output logic crystal_pin_b_direction,
  output logic lp_osc_run,
  output logic rollover_flag,
  output logic wake_request,
  output logic [15:0] count_value
);

  typedef struct packed {
    // control fields
    logic timer_on;
    logic clock_source_select;
    logic external_sync_disable;
    logic low_power_osc_enable;
    logic [1:0] prescale_select;
    // counter and its flags
    logic [15:0] count;
    logic rollover_flag;
    logic armed;
    // instruction clock divider
    logic [1:0] instr_phase;
    logic instr_tick;
    // axi write side
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    // axi read side
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    // pin, oscillator and wake outputs
    logic pin_a_dir;
    logic pin_b_dir;
    logic lp_osc_run;
    logic wake_request;
  } main_state_t;

  main_state_t s;
  main_state_t next_s;

  logic osc_running;     // oscillator enabled and allowed in this mode
  logic ext_level;       // selected external clock level
  logic ext_rise;        // rising edge of the external clock
  logic ext_fall;        // falling edge of the external clock
  logic direct_mode;     // external source with synchroniser bypassed
  logic count_tick;      // tick entering the prescaler
  logic pre_pulse;       // tick leaving the prescaler
  logic count_write;     // software writes a counter byte
  logic aw_go;           // write address handshake this cycle
  logic w_go;            // write data handshake this cycle
  logic ar_go;           // read address handshake this cycle
  logic [7:0] wr_addr;   // address of the write being performed
  logic [31:0] wr_data;  // data of the write being performed
  logic [3:0] wr_strb;   // strobes of the write being performed
  logic do_write;        // both halves present, response slot free
  logic [31:0] rd_word;  // read mux result

  // oscillator only usable in the lp or internal-oscillator modes
  assign osc_running = s.low_power_osc_enable & osc_mode_lp_or_intosc;

  // pin or crystal oscillator as the external source
  assign ext_level = osc_running ? low_power_crystal_osc : external_clock_pin;

  // internal source makes the sync-disable bit irrelevant
  assign direct_mode = s.clock_source_select & s.external_sync_disable;

  // external edge finder; direct sample or two-stage synchroniser
  clock_edge_detect u_edge (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .level(ext_level),
    .sync_bypass(direct_mode),
    .rise(ext_rise),
    .fall(ext_fall)
  );

  // hidden prescaler shared by both sources
  count_prescaler u_prescale (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .tick(count_tick),
    .clear(count_write),
    .prescale_select(s.prescale_select),
    .pulse(pre_pulse)
  );

  // select the counting tick; sleep stops all but direct counting
  always_comb begin
    count_tick = 1'b0;
    if (s.timer_on) begin
      if (!s.clock_source_select) begin
        // instruction cycles, stopped with the core in sleep
        count_tick = s.instr_tick & ~sleep_mode;
      end else begin
        // rising edges only once a falling edge was seen
        count_tick = ext_rise & s.armed & (direct_mode | ~sleep_mode);
      end
    end
  end

  // axi handshakes and the write that results from them
  assign aw_go = s_axi_awvalid & s.awready;
  assign w_go = s_axi_wvalid & s.wready;
  assign ar_go = s_axi_arvalid & s.arready;
  assign wr_addr = s.aw_held ? s.aw_addr : s_axi_awaddr;
  assign wr_data = s.w_held ? s.w_data : s_axi_wdata;
  assign wr_strb = s.w_held ? s.w_strb : s_axi_wstrb;
  assign do_write = (s.aw_held | aw_go) & (s.w_held | w_go) & ~s.bvalid;
  // only the low byte lane carries register data
  assign count_write = do_write & wr_strb[0] &
                       ((wr_addr == count_low_offset) | (wr_addr == count_high_offset));

  // read mux; reserved bits read as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      ctrl_offset: begin
        rd_word[timer_on_bit] = s.timer_on;
        rd_word[clock_source_select_bit] = s.clock_source_select;
        rd_word[external_sync_disable_bit] = s.external_sync_disable;
        rd_word[low_power_osc_enable_bit] = s.low_power_osc_enable;
        rd_word[prescale_select_lsb +: 2] = s.prescale_select;
      end
      count_low_offset: begin
        rd_word[7:0] = s.count[7:0];
      end
      count_high_offset: begin
        rd_word[7:0] = s.count[15:8];
      end
      status_offset: begin
        rd_word[rollover_flag_bit] = s.rollover_flag;
        rd_word[armed_bit] = s.armed;
        rd_word[osc_usable_bit] = osc_running;
      end
      crystal_pins_offset: begin
        // crystal pins read as inputs with data low while oscillating
        rd_word[pin_a_dir_bit] = osc_running | port_pin_a_direction;
        rd_word[pin_b_dir_bit] = osc_running | port_pin_b_direction;
        rd_word[pin_a_data_bit] = ~osc_running & port_pin_a_data;
        rd_word[pin_b_data_bit] = ~osc_running & port_pin_b_data;
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  // next-state logic for the whole block
  always_comb begin
    next_s = s;

    // instruction clock enable: one pulse every four core cycles
    next_s.instr_phase = s.instr_phase + 2'h1;
    next_s.instr_tick = (s.instr_phase == instr_phase_last);

    // arming for counter mode: off or any counter byte write disarms
    if (!s.timer_on || count_write) begin
      next_s.armed = 1'b0;
    end else if (ext_fall) begin
      next_s.armed = 1'b1;
    end

    // counting; the prescaled tick advances only while on
    if (pre_pulse && s.timer_on) begin
      next_s.count = s.count + 16'h0001;
      if (s.count == count_max) begin
        next_s.rollover_flag = 1'b1;
      end
    end

    // capture write halves that arrive alone
    if (aw_go) begin
      next_s.aw_held = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (w_go) begin
      next_s.w_held = 1'b1;
      next_s.w_data = s_axi_wdata;
      next_s.w_strb = s_axi_wstrb;
    end

    // perform the write; a counter write beats a same-cycle increment
    if (do_write) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = resp_okay;
      case (wr_addr)
        ctrl_offset: begin
          if (wr_strb[0]) begin
            next_s.timer_on = wr_data[timer_on_bit];
            next_s.clock_source_select = wr_data[clock_source_select_bit];
            next_s.external_sync_disable = wr_data[external_sync_disable_bit];
            next_s.low_power_osc_enable = wr_data[low_power_osc_enable_bit];
            next_s.prescale_select = wr_data[prescale_select_lsb +: 2];
          end
        end
        count_low_offset: begin
          if (wr_strb[0]) begin
            next_s.count = {s.count[15:8], wr_data[7:0]};
          end
        end
        count_high_offset: begin
          if (wr_strb[0]) begin
            next_s.count = {wr_data[7:0], s.count[7:0]};
          end
        end
        status_offset: begin
          // write one clears; a rollover in the same cycle still sets
          if (wr_strb[0] && wr_data[rollover_flag_bit] &&
              !(pre_pulse && s.timer_on && s.count == count_max)) begin
            next_s.rollover_flag = 1'b0;
          end
        end
        crystal_pins_offset: begin
          // readback only; writes are accepted and dropped
          next_s.bresp = resp_okay;
        end
        default: begin
          next_s.bresp = resp_slverr;
        end
      endcase
    end

    // write response retires on bready
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end

    // write channels accept while their half is free and no response waits
    next_s.awready = ~next_s.aw_held & ~next_s.bvalid;
    next_s.wready = ~next_s.w_held & ~next_s.bvalid;

    // read: one outstanding, data registered at the address handshake
    if (ar_go) begin
      next_s.rvalid = 1'b1;
      next_s.rdata = rd_word;
      next_s.rresp = (s_axi_araddr == ctrl_offset || s_axi_araddr == count_low_offset ||
                      s_axi_araddr == count_high_offset || s_axi_araddr == status_offset ||
                      s_axi_araddr == crystal_pins_offset) ? resp_okay : resp_slverr;
    end else if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    next_s.arready = ~next_s.rvalid;

    // pins forced to inputs while the crystal runs
    next_s.pin_a_dir = osc_running | port_pin_a_direction;
    next_s.pin_b_dir = osc_running | port_pin_b_direction;
    next_s.lp_osc_run = osc_running;

    // wake whenever the rollover flag is set while in sleep
    next_s.wake_request = next_s.rollover_flag & sleep_mode;
  end

  // state register; control state all zero after reset
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s <= '0;
      s.timer_on <= ctrl_reset[timer_on_bit];
      s.count <= count_reset;
      s.pin_a_dir <= 1'b1;
      s.pin_b_dir <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from flops
  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign crystal_pin_a_direction = s.pin_a_dir;
  assign crystal_pin_b_direction = s.pin_b_dir;
  assign lp_osc_run = s.lp_osc_run;
  assign rollover_flag = s.rollover_flag;
  assign wake_request = s.wake_request;
  assign count_value = s.count;

endmodule : gated_timer16

// ===== tb/timer16_chk.sv
// port assertions for the 16-bit timer, bound into its top
module timer16_chk
  import timer16_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic osc_mode_lp_or_intosc,
  input wire logic sleep_mode,
  input wire logic crystal_pin_a_direction,
  input wire logic crystal_pin_b_direction,
  input wire logic lp_osc_run,
  input wire logic rollover_flag,
  input wire logic wake_request,
  input wire logic [15:0] count_value
);
  timeunit 1ns;
  timeprecision 1ns;
  logic wr_take; // both write halves taken
  logic rd_take; // read address taken
  assign wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign rd_take = s_axi_arvalid && s_axi_arready;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // a taken write, then its raised answer
  sequence write_taken;
    wr_take;
  endsequence
  sequence answer_up;
    s_axi_bvalid && !s_axi_awready;
  endsequence
  chk_write_answer: assert property (write_taken |=> answer_up)
    else $error("write taken but no response");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_read_answer: assert property (rd_take |=> s_axi_rvalid)
    else $error("read taken but no data");
  chk_unmapped_err: assert property (write_taken ##0 s_axi_awaddr > crystal_pins_offset |=> s_axi_bresp == resp_slverr)
    else $error("unmapped write not refused");
  // outside writes the count only steps by one, wrapping at the top
  chk_count_step: assert property ($changed(count_value) && !$rose(s_axi_bvalid) |->
    count_value == $past(count_value) + 16'h0001)
    else $error("count moved by other than one");
  chk_rollover_set: assert property ($past(count_value) == count_max && count_value == 16'h0000
    && !$rose(s_axi_bvalid) |-> ##[0:1] rollover_flag)
    else $error("wrap without flag");
  chk_flag_sticky: assert property (rollover_flag && !wr_take |=> rollover_flag)
    else $error("flag cleared without a write");
  chk_osc_dirs: assert property (lp_osc_run && $past(lp_osc_run) |->
    crystal_pin_a_direction && crystal_pin_b_direction)
    else $error("pin directions not forced");
  chk_osc_mode: assert property ($rose(lp_osc_run) |-> $past(osc_mode_lp_or_intosc))
    else $error("oscillator run in wrong mode");
  chk_wake_flag: assert property (rollover_flag && sleep_mode && $past(rollover_flag && sleep_mode)
    |-> wake_request)
    else $error("no wake on flag in sleep");
endmodule : timer16_chk
bind gated_timer16 timer16_chk chk (.*);

// ===== tb/clock_source_model.sv
// far-side clock source: pin or crystal pulses
module clock_source_model (
  input wire logic core_clk,
  input wire logic use_crystal,
  output logic external_clock_pin,
  output logic low_power_crystal_osc
);
  timeunit 1ns;
  timeprecision 1ns;
  logic level = 1'b0; // selected line, still between bursts
  logic noise = 1'b0; // unused line toggles so a wrong pick miscounts
  always @(posedge core_clk) begin
    noise <= !noise;
  end
  assign external_clock_pin = use_crystal ? noise : level;
  assign low_power_crystal_osc = use_crystal ? level : noise;
  // n full pulses, each phase half core cycles long
  task automatic burst(input int n, input int half);
    for (int i = 0; i < n; i++) begin
      repeat (half) @(posedge core_clk);
      level <= 1'b1;
      repeat (half) @(posedge core_clk);
      level <= 1'b0;
    end
  endtask : burst
endmodule : clock_source_model

// ===== tb/gated_timer16_tb_top.sv
// self-checking bench: register tasks, count rows, edge cases
module gated_timer16_tb_top
  import timer16_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // row: prescale, direct, crystal, asleep, expected count
  typedef struct packed {
    logic [1:0] ps;
    logic direct;
    logic xtal;
    logic sleep;
    logic [15:0] exp;
  } row_t;
  // 17 pulses from low: first rise unarmed, 16 counted
  row_t rows [8] = '{
    '{2'h0, 1'b0, 1'b0, 1'b0, 16'h0010},
    '{2'h1, 1'b0, 1'b0, 1'b0, 16'h0008},
    '{2'h2, 1'b1, 1'b0, 1'b0, 16'h0004},
    '{2'h3, 1'b1, 1'b0, 1'b0, 16'h0002},
    '{2'h0, 1'b1, 1'b1, 1'b0, 16'h0010},
    '{2'h3, 1'b0, 1'b1, 1'b0, 16'h0002},
    '{2'h2, 1'b1, 1'b0, 1'b1, 16'h0004},
    '{2'h0, 1'b0, 1'b0, 1'b1, 16'h0000}
  };
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp_seen;
  logic [31:0] s_axi_rdata, rdata_seen, ctl;
  logic osc_mode_lp_or_intosc = 1'b1, sleep_mode = 1'b0, use_crystal = 1'b0;
  logic port_pin_a_direction = 1'b0, port_pin_b_direction = 1'b0;
  logic port_pin_a_data = 1'b1, port_pin_b_data = 1'b1;
  logic external_clock_pin, low_power_crystal_osc, lp_osc_run;
  logic crystal_pin_a_direction, crystal_pin_b_direction, rollover_flag, wake_request;
  logic [15:0] count_value, held;
  int errors = 0;
  int comparisons = 0;
  gated_timer16 dut (.*);
  clock_source_model src (.core_clk, .use_crystal, .external_clock_pin, .low_power_crystal_osc);
  // 100 ns core clock
  initial begin
    forever #50 core_clk = !core_clk;
  end
  // one write; both halves offered together, released as taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready && !aw_done) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready && !w_done) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(aw_done && w_done));
    while (!s_axi_bvalid) @(posedge core_clk);
    resp_seen = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_write
  // one read, data and code taken at the rvalid edge
  task automatic axi_read(input logic [7:0] a);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge core_clk);
    rdata_seen = s_axi_rdata;
    resp_seen = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_read
  // compare and count
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic conclude;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  // hang guard, well past the few thousand cycles expected
  initial begin
    repeat (30000) @(posedge core_clk);
    errors++;
    conclude();
  end
  initial begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      use_crystal <= rows[i].xtal;
      sleep_mode <= rows[i].sleep;
      ctl = {26'h0, rows[i].ps, rows[i].xtal, rows[i].direct, 2'b10};
      axi_write(ctrl_offset, ctl);
      repeat (40) @(posedge core_clk);
      axi_write(count_low_offset, 32'h0000_0000);
      axi_write(count_high_offset, 32'h0000_0000);
      axi_write(ctrl_offset, ctl | 32'h0000_0001);
      src.burst(17, 4);
      repeat (12) @(posedge core_clk);
      axi_write(ctrl_offset, ctl);
      sleep_mode <= 1'b0;
      axi_read(count_low_offset);
      check("count low", {24'h0, rows[i].exp[7:0]}, rdata_seen);
      check("count port", {16'h0, rows[i].exp}, {16'h0, count_value});
      $display("row %0d done", i);
    end
    // second reset in mid-run, then reset values
    rst_n <= 1'b0;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    axi_read(ctrl_offset);
    check("ctrl reset", 32'h0000_0000, rdata_seen);
    axi_read(count_high_offset);
    check("high reset", 32'h0000_0000, rdata_seen);
    axi_read(crystal_pins_offset);
    check("pins idle", 32'h0000_000c, rdata_seen);
    check("dirs idle", 32'h0, {30'h0, crystal_pin_b_direction, crystal_pin_a_direction});
    // oscillator on forces directions, masks data
    axi_write(ctrl_offset, 32'h0000_0008);
    axi_read(crystal_pins_offset);
    check("pins forced", 32'h0000_0003, rdata_seen);
    check("osc run", 32'h1, {31'h0, lp_osc_run});
    check("dirs forced", 32'h3, {30'h0, crystal_pin_b_direction, crystal_pin_a_direction});
    osc_mode_lp_or_intosc <= 1'b0;
    repeat (3) @(posedge core_clk);
    check("osc mode off", 32'h0, {31'h0, lp_osc_run});
    osc_mode_lp_or_intosc <= 1'b1;
    $display("reset and oscillator done");
    // unmapped place refused
    axi_write(8'h20, 32'h0000_0001);
    check("bad write resp", {30'h0, resp_slverr}, {30'h0, resp_seen});
    axi_read(8'h20);
    check("bad read data", 32'h0000_0000, rdata_seen);
    check("bad read resp", {30'h0, resp_slverr}, {30'h0, resp_seen});
    // byte writes land straight in the counter
    axi_write(count_low_offset, 32'h0000_005a);
    check("low write resp", {30'h0, resp_okay}, {30'h0, resp_seen});
    axi_write(count_high_offset, 32'h0000_00a5);
    check("byte load", 32'h0000_a55a, {16'h0, count_value});
    $display("bus and byte load done");
    // wrap from the top on the internal clock
    axi_write(count_low_offset, 32'h0000_00ff);
    axi_write(count_high_offset, 32'h0000_00ff);
    // sync-disable set on the internal source must not matter
    axi_write(ctrl_offset, 32'h0000_0005);
    repeat (24) @(posedge core_clk);
    axi_write(ctrl_offset, 32'h0000_0000);
    held = count_value;
    check("wrapped low", 32'h1, {31'h0, count_value < 16'h0010 && count_value != 16'h0000});
    check("flag set", 32'h1, {31'h0, rollover_flag});
    // awake, so only the off bit can hold the count
    repeat (20) @(posedge core_clk);
    check("held when off", {16'h0, held}, {16'h0, count_value});
    sleep_mode <= 1'b1;
    repeat (3) @(posedge core_clk);
    check("wake", 32'h1, {31'h0, wake_request});
    sleep_mode <= 1'b0;
    axi_write(status_offset, 32'h0000_0001);
    axi_read(status_offset);
    check("flag cleared", 32'h0, {31'h0, rdata_seen[rollover_flag_bit]});
    $display("wrap and flag done");
    conclude();
  end
endmodule : gated_timer16_tb_top
